// File: core/fdr_rate_ctrl.sv
// Purpose: Host drive control registers of a floppy controller
// Assumes: Host I/O strobes and all config inputs on clk_sys_in
// Notes: Strobes are one cycle per access
//
// Function
// - Motor bits 4,5 drive motor pins 0,1
// - Motor bits 6,7 drive no pin
// - Normal decode of selects and motors
// - Swapped decode exchanges selects and motors
// - Tape select encodes drive 1 to 3
// - Drive 0 never gets tape support
// - Tape register survives software reset
// - Normal mode tape reads zero high bits
// - Enhanced mode returns type, boot, tape
// - Type ID picks config pair by select
// - Active rate is last rate written
// - Hardware reset loads 02H, software keeps
// - Rate register field layout
// - Precompensation code selects write delay
// - Default code delay depends on rate
// - Precompensation starts at configurable track
// - Low power bit, ended by access
// - Self-clearing software reset bit
// - Standard rate select to density mapping
// - Three-mode and tape rate exceptions
// - Density pin mapping per drive type
// - Binary drive select, one drive only
// - Reset bit zero holds software reset
`timescale 1ns/1ps
`include "fdr_defines.svh"
module fdr_rate_ctrl (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [9:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    input wire fdr_pkg::fdr_decode_t decode_mode_in,
    input wire logic enhanced_mode_in,
    input wire logic [7:0] drive_type_config_reg_in,
    input wire fdr_pkg::fdr_rate_type_t drive_rate_type_in,
    input wire logic [7:0] code_a_start_track_in,
    input wire logic [7:0] current_track_in,
    output logic drive_pick_zero_n_out,
    output logic drive_pick_one_n_out,
    output logic motor_out_zero_n_out,
    output logic motor_out_one_n_out,
    output logic density_level_out,
    output logic [1:0] rate_code_out,
    output logic [1:0] drive_density_pins_out,
    output logic [2:0] code_a_out,
    output logic [5:0] code_a_delay_cycles_out,
    output logic code_a_enable_out,
    output logic low_power_out,
    output logic controller_reset_out
);
    localparam int SRST_CYC = `FDR_SRST_CYC;

    logic [7:0] drive_output_control;
    logic [7:0] rate_code_a_select;
    logic [1:0] tape_sel;
    logic [1:0] boot_drive;
    logic [1:0] active_rate;
    logic low_power;
    logic [5:0] srst_cnt;
    logic wr_doc;
    logic wr_tda;
    logic wr_rps;
    logic wr_crc;
    logic status_touch;
    logic [1:0] type_id;
    logic [7:0] next_rdata;

    fdr_rate_if rif ();

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    always_comb begin
        wr_doc = io_wr_in && (io_addr_in == `FDR_OFS_DOC);
        wr_tda = io_wr_in && (io_addr_in == `FDR_OFS_TDA);
        wr_rps = io_wr_in && (io_addr_in == `FDR_OFS_RPS);
        wr_crc = io_wr_in && (io_addr_in == `FDR_OFS_CRC);
        status_touch = ((io_wr_in || io_rd_in) && (io_addr_in == `FDR_OFS_DATA))
            || (io_rd_in && (io_addr_in == `FDR_OFS_RPS));
    end

    // ----------------------------------------
    // Drive output control
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            drive_output_control <= `FDR_RST_DOC;
        end else if (wr_doc) begin
            drive_output_control <= io_wdata_in;
        end
    end

    // ----------------------------------------
    // Tape assignment
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            tape_sel <= 2'(`FDR_RST_TDA);
            boot_drive <= 2'h0;
        end else if (wr_tda) begin
            tape_sel <= io_wdata_in[1:0];
            if (enhanced_mode_in) begin
                boot_drive <= io_wdata_in[3:2];
            end
        end
    end

    // ----------------------------------------
    // Rate and precompensation select
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rate_code_a_select <= `FDR_RST_RPS;
        end else if (wr_rps) begin
            rate_code_a_select <= io_wdata_in & ~(8'h01 << `FDR_RPS_ZERO);
        end else begin
            rate_code_a_select[`FDR_RPS_SWRST] <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            active_rate <= `FDR_RST_RATE;
        end else if (wr_rps || wr_crc) begin
            active_rate <= io_wdata_in[`FDR_RPS_RATE_HI:`FDR_RPS_RATE_LO];
        end
    end

    // ----------------------------------------
    // Software reset stretch
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            srst_cnt <= 6'h0;
        end else if (wr_rps && io_wdata_in[`FDR_RPS_SWRST]) begin
            srst_cnt <= 6'(SRST_CYC);
        end else if (srst_cnt != 6'h0) begin
            srst_cnt <= srst_cnt - 6'h1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            controller_reset_out <= 1'h1;
        end else begin
            controller_reset_out <= ~drive_output_control[`FDR_DOC_NRESET]
                || (srst_cnt != 6'h0);
        end
    end

    // ----------------------------------------
    // Low power
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            low_power <= 1'h0;
        end else if (wr_rps && io_wdata_in[`FDR_RPS_LOWPWR]
            && !io_wdata_in[`FDR_RPS_SWRST]) begin
            low_power <= 1'h1;
        end else if (status_touch || controller_reset_out || (srst_cnt != 6'h0)) begin
            low_power <= 1'h0;
        end
    end

    assign low_power_out = low_power;

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        case (drive_output_control[`FDR_DOC_SEL_HI:`FDR_DOC_SEL_LO])
            2'h0: type_id = drive_type_config_reg_in[1:0];
            2'h1: type_id = drive_type_config_reg_in[3:2];
            2'h2: type_id = drive_type_config_reg_in[5:4];
            default: type_id = drive_type_config_reg_in[7:6];
        endcase
        next_rdata = 8'h00;
        if (io_addr_in == `FDR_OFS_DOC) begin
            next_rdata = drive_output_control;
        end else if (io_addr_in == `FDR_OFS_TDA) begin
            if (enhanced_mode_in) begin
                next_rdata = {2'h0, type_id, boot_drive, tape_sel};
            end else begin
                next_rdata = {6'h00, tape_sel};
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            io_rdata_out <= 8'h00;
        end else if (io_rd_in) begin
            io_rdata_out <= next_rdata;
        end
    end

    // ----------------------------------------
    // Precompensation start
    // ----------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            code_a_enable_out <= 1'h0;
            code_a_out <= `FDR_PC_DEFAULT;
        end else begin
            code_a_enable_out <= current_track_in >= code_a_start_track_in;
            code_a_out <= rate_code_a_select[`FDR_RPS_PC_HI:`FDR_RPS_PC_LO];
        end
    end

    // ----------------------------------------
    // Mapping and decode
    // ----------------------------------------
    assign rif.rate_sel = active_rate;
    assign rif.code_a_code = rate_code_a_select[`FDR_RPS_PC_HI:`FDR_RPS_PC_LO];
    assign rif.rate_type = drive_rate_type_in;
    assign density_level_out = rif.density;
    assign rate_code_out = rif.rate_code;
    assign drive_density_pins_out = rif.drive_density_pins;
    assign code_a_delay_cycles_out = rif.code_a_cycles;

    fdr_rate_map u_map (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .rif(rif.map)
    );

    // Bits 6 and 7 reach no pin
    fdr_drive_decode u_dec (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .doc_in(drive_output_control & 8'h3F),
        .mode_in(decode_mode_in),
        .drive_pick_zero_n_out(drive_pick_zero_n_out),
        .drive_pick_one_n_out(drive_pick_one_n_out),
        .motor_out_zero_n_out(motor_out_zero_n_out),
        .motor_out_one_n_out(motor_out_one_n_out)
    );
endmodule // fdr_rate_ctrl

// File: core/fdr_defines.svh
// Purpose: Named offsets, fields, reset values and timing of the drive rate control block
// Assumes: 250 MHz system clock
// Notes: Definitions only
`ifndef FDR_DEFINES_SVH
`define FDR_DEFINES_SVH

// ----------------------------------------
// Port offsets
// ----------------------------------------
`define FDR_OFS_DOC 10'h3F2
`define FDR_OFS_TDA 10'h3F3
`define FDR_OFS_RPS 10'h3F4
`define FDR_OFS_DATA 10'h3F5
`define FDR_OFS_CRC 10'h3F7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FDR_RST_DOC 8'h00
`define FDR_RST_RPS 8'h02
`define FDR_RST_TDA 8'h00
`define FDR_RST_RATE 2'h2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FDR_DOC_SEL_HI 1
`define FDR_DOC_SEL_LO 0
`define FDR_DOC_NRESET 2
`define FDR_DOC_MOT0 4
`define FDR_DOC_MOT1 5
`define FDR_DOC_MOT2 6
`define FDR_DOC_MOT3 7
`define FDR_RPS_SWRST 7
`define FDR_RPS_LOWPWR 6
`define FDR_RPS_ZERO 5
`define FDR_RPS_PC_HI 4
`define FDR_RPS_PC_LO 2
`define FDR_RPS_RATE_HI 1
`define FDR_RPS_RATE_LO 0

// ----------------------------------------
// Codes
// ----------------------------------------
`define FDR_RATE_1M 2'h3
`define FDR_RATE_SEL01 2'h1
`define FDR_RATE_500 2'h0
`define FDR_PC_DEFAULT 3'h0
`define FDR_PC_NONE 3'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define FDR_CLK_PS 4000
`define FDR_SRST_MIN_NS 100
`define FDR_SRST_CYC ((`FDR_SRST_MIN_NS * 1000 + `FDR_CLK_PS - 1) / `FDR_CLK_PS)

// ----------------------------------------
// Precompensation delays in ps
// ----------------------------------------
`define FDR_PC_PS_1 41670
`define FDR_PC_PS_2 83340
`define FDR_PC_PS_3 125000
`define FDR_PC_PS_4 166670
`define FDR_PC_PS_5 208330
`define FDR_PC_PS_6 250000
`define FDR_PC2M_PS_1 20800
`define FDR_PC2M_PS_2 41700
`define FDR_PC2M_PS_3 62500
`define FDR_PC2M_PS_4 83300
`define FDR_PC2M_PS_5 104200
`define FDR_PC2M_PS_6 125000
`define FDR_PCDEF_2M_PS 20800
`define FDR_PCDEF_1M_PS 41670
`define FDR_PCDEF_LOW_PS 125000

`endif

// File: core/fdr_pkg.sv
// Purpose: Types shared by the drive rate control block
// Assumes: Nothing
// Notes: Used by package-qualified names only
package fdr_pkg;

    typedef enum logic [1:0] {
        FDR_TYPE_STD = 2'h0,
        FDR_TYPE_THREE = 2'h1,
        FDR_TYPE_TAPE = 2'h2,
        FDR_TYPE_ALT = 2'h3
    } fdr_rate_type_t;

    typedef enum logic {
        FDR_DEC_NORMAL = 1'h0,
        FDR_DEC_SWAP = 1'h1
    } fdr_decode_t;

endpackage

// File: core/fdr_rate_if.sv
// Purpose: Carries rate settings to the mapping module and results back
// Assumes: Single clock
// Notes: ctl side drives settings, map side drives results
`timescale 1ns/1ps
interface fdr_rate_if;
    logic [1:0] rate_sel;
    logic [2:0] code_a_code;
    fdr_pkg::fdr_rate_type_t rate_type;
    logic density;
    logic [1:0] rate_code;
    logic [1:0] drive_density_pins;
    logic [5:0] code_a_cycles;

    modport ctl (
        output rate_sel,
        output code_a_code,
        output rate_type,
        input density,
        input rate_code,
        input drive_density_pins,
        input code_a_cycles
    );

    modport map (
        input rate_sel,
        input code_a_code,
        input rate_type,
        output density,
        output rate_code,
        output drive_density_pins,
        output code_a_cycles
    );
endinterface // fdr_rate_if

// File: core/fdr_drive_decode.sv
// Purpose: Drive select and motor pin decode
// Assumes: Drive output control value from the same clock
// Notes: Pins are registered, active low
`timescale 1ns/1ps
`include "fdr_defines.svh"
module fdr_drive_decode (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [7:0] doc_in,
    input wire fdr_pkg::fdr_decode_t mode_in,
    output logic drive_pick_zero_n_out,
    output logic drive_pick_one_n_out,
    output logic motor_out_zero_n_out,
    output logic motor_out_one_n_out
);
    logic m0;
    logic m1;
    logic [1:0] sel;
    logic next_pick0;
    logic next_pick1;

    assign m0 = doc_in[`FDR_DOC_MOT0];
    assign m1 = doc_in[`FDR_DOC_MOT1];
    assign sel = doc_in[`FDR_DOC_SEL_HI:`FDR_DOC_SEL_LO];

    // ----------------------------------------
    // Select decode
    // ----------------------------------------
    always_comb begin
        next_pick0 = (sel == 2'h0) && m0;
        next_pick1 = (sel == 2'h1) && m1;
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            drive_pick_zero_n_out <= 1'h1;
            drive_pick_one_n_out <= 1'h1;
            motor_out_zero_n_out <= 1'h1;
            motor_out_one_n_out <= 1'h1;
        end else if (mode_in == fdr_pkg::FDR_DEC_SWAP) begin
            drive_pick_zero_n_out <= ~next_pick1;
            drive_pick_one_n_out <= ~next_pick0;
            motor_out_zero_n_out <= ~m1;
            motor_out_one_n_out <= ~m0;
        end else begin
            drive_pick_zero_n_out <= ~next_pick0;
            drive_pick_one_n_out <= ~next_pick1;
            motor_out_zero_n_out <= ~m0;
            motor_out_one_n_out <= ~m1;
        end
    end
endmodule // fdr_drive_decode

// File: core/fdr_rate_map.sv
// Purpose: Data rate to density, rate code and precompensation mapping
// Assumes: Settings from the same clock
// Notes: Results registered
`timescale 1ns/1ps
`include "fdr_defines.svh"
module fdr_rate_map (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    fdr_rate_if.map rif
);
    logic is_2m;
    logic is_1m;
    logic dens;

    // ----------------------------------------
    // Delay lookup
    // ----------------------------------------
    function automatic logic [5:0] fdr_cyc(input int ps);
        fdr_cyc = 6'(ps / `FDR_CLK_PS);
    endfunction

    function automatic int fdr_pc_ps(input logic [2:0] code, input logic fast, input logic one_m);
        int v;
        v = 0;
        case (code)
            3'h1: v = fast ? `FDR_PC2M_PS_1 : `FDR_PC_PS_1;
            3'h2: v = fast ? `FDR_PC2M_PS_2 : `FDR_PC_PS_2;
            3'h3: v = fast ? `FDR_PC2M_PS_3 : `FDR_PC_PS_3;
            3'h4: v = fast ? `FDR_PC2M_PS_4 : `FDR_PC_PS_4;
            3'h5: v = fast ? `FDR_PC2M_PS_5 : `FDR_PC_PS_5;
            3'h6: v = fast ? `FDR_PC2M_PS_6 : `FDR_PC_PS_6;
            `FDR_PC_NONE: v = 0;
            default: v = fast ? `FDR_PCDEF_2M_PS : (one_m ? `FDR_PCDEF_1M_PS
                : `FDR_PCDEF_LOW_PS);
        endcase
        return v;
    endfunction

    always_comb begin
        is_2m = (rif.rate_type == fdr_pkg::FDR_TYPE_TAPE)
            && (rif.rate_sel == `FDR_RATE_SEL01);
        is_1m = (rif.rate_sel == `FDR_RATE_1M);
        dens = (rif.rate_sel == `FDR_RATE_1M) || (rif.rate_sel == `FDR_RATE_500);
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rif.density <= 1'h0;
            rif.rate_code <= `FDR_RST_RATE;
            rif.drive_density_pins <= 2'h0;
            rif.code_a_cycles <= 6'h0;
        end else begin
            rif.density <= dens;
            rif.rate_code <= rif.rate_sel;
            rif.code_a_cycles <= fdr_cyc(fdr_pc_ps(rif.code_a_code, is_2m, is_1m));
            case (rif.rate_type)
                fdr_pkg::FDR_TYPE_STD: rif.drive_density_pins <= {rif.rate_sel[0], dens};
                fdr_pkg::FDR_TYPE_TAPE: rif.drive_density_pins <= {rif.rate_sel[0], rif.rate_sel[1]};
                fdr_pkg::FDR_TYPE_THREE: rif.drive_density_pins <= {rif.rate_sel[0], ~dens};
                default: rif.drive_density_pins <= {rif.rate_sel[1], rif.rate_sel[0]};
            endcase
        end
    end
endmodule // fdr_rate_map

// File: testbench/fdr_rate_ctrl_sva.sv
// Purpose: Port assertions for the drive rate control block
// Assumes: One clock, synchronous active-high reset
// Notes: Attached by bind
`timescale 1ns/1ps
module fdr_rate_ctrl_sva (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [9:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic [7:0] io_rdata_out,
    input wire fdr_pkg::fdr_decode_t decode_mode_in,
    input wire fdr_pkg::fdr_rate_type_t drive_rate_type_in,
    input wire logic drive_pick_zero_n_out,
    input wire logic drive_pick_one_n_out,
    input wire logic motor_out_zero_n_out,
    input wire logic motor_out_one_n_out,
    input wire logic density_level_out,
    input wire logic [1:0] rate_code_out,
    input wire logic [1:0] drive_density_pins_out,
    input wire logic low_power_out,
    input wire logic controller_reset_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    logic wd, wrt, w4, nrm;
    assign wd = io_wr_in && io_addr_in == 10'h3F2;
    assign w4 = io_wr_in && io_addr_in == 10'h3F4;
    assign wrt = w4 || (io_wr_in && io_addr_in == 10'h3F7);
    assign nrm = decode_mode_in == fdr_pkg::FDR_DEC_NORMAL;
    // ----------
    // Assertions
    // ----------
    AST_PICK0_NORMAL: assert property (wd && io_wdata_in[1:0] == 2'h0 && io_wdata_in[4]
        ##1 !io_wr_in && nrm |=> !drive_pick_zero_n_out) else $error("select 0 idle");
    AST_MOTOR_NORMAL: assert property (wd ##1 !io_wr_in && nrm |=>
        motor_out_zero_n_out == !$past(io_wdata_in[4], 2)
        && motor_out_one_n_out == !$past(io_wdata_in[5], 2)) else $error("motor normal");
    AST_MOTOR_SWAP: assert property (wd ##1 !io_wr_in && !nrm |=>
        motor_out_one_n_out == !$past(io_wdata_in[4], 2)
        && motor_out_zero_n_out == !$past(io_wdata_in[5], 2)) else $error("motor swap");
    AST_ONE_PICK: assert property (drive_pick_zero_n_out || drive_pick_one_n_out)
        else $error("two selects");
    AST_RATE_FOLLOW: assert property (wrt ##1 !wrt |=>
        rate_code_out == $past(io_wdata_in[1:0], 2)) else $error("rate code");
    AST_DENSITY: assert property (density_level_out
        == (rate_code_out == 2'h0 || rate_code_out == 2'h3)) else $error("density");
    AST_DRIVE_DENSITY_PINS_STD: assert property (drive_rate_type_in == fdr_pkg::FDR_TYPE_STD [*3]
        |-> drive_density_pins_out == {rate_code_out[0], density_level_out})
        else $error("density pins");
    AST_SWRST_HOLD: assert property (w4 && io_wdata_in[7] |=> ##1 controller_reset_out [*8])
        else $error("soft reset short");
    AST_DOC_RESET: assert property (wd && !io_wdata_in[2] ##1 !io_wr_in
        |=> controller_reset_out) else $error("reset bit");
    AST_LOWPWR_SET: assert property (w4 && io_wdata_in[7:6] == 2'h1 && !controller_reset_out
        |=> low_power_out) else $error("low power set");
    AST_LOWPWR_CLR: assert property ((io_rd_in || io_wr_in) && io_addr_in == 10'h3F5
        |=> !low_power_out) else $error("low power clear");
    AST_RDATA_HOLD: assert property (!io_rd_in |=> $stable(io_rdata_out))
        else $error("read data moved");
    COV_SWAP: cover property (wd ##1 !nrm);
    COV_SWRST: cover property (w4 && io_wdata_in[7]);
    COV_LOWPWR: cover property (low_power_out ##1 !low_power_out);
endmodule // fdr_rate_ctrl_sva

bind fdr_rate_ctrl fdr_rate_ctrl_sva i_fdr_rate_ctrl_sva (
    .clk_sys_in, .reset_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in, .io_rdata_out,
    .decode_mode_in, .drive_rate_type_in, .drive_pick_zero_n_out, .drive_pick_one_n_out,
    .motor_out_zero_n_out, .motor_out_one_n_out, .density_level_out, .rate_code_out,
    .drive_density_pins_out, .low_power_out, .controller_reset_out
);

// File: testbench/fdr_drive_model.sv
// Purpose: Two floppy drives on the disk cable
// Assumes: Active-low select and motor pins
// Notes: Reports selected and spinning drives
`timescale 1ns/1ps
module fdr_drive_model (
    input wire logic clk_sys_in,
    input wire logic drive_pick_zero_n_in,
    input wire logic drive_pick_one_n_in,
    input wire logic motor_out_zero_n_in,
    input wire logic motor_out_one_n_in,
    output logic [1:0] selected_out,
    output logic [1:0] spinning_out
);
    // Drive 0 is the boot disk, never a tape
    always_ff @(posedge clk_sys_in) begin
        selected_out <= {!drive_pick_one_n_in, !drive_pick_zero_n_in};
        spinning_out <= {!motor_out_one_n_in, !motor_out_zero_n_in};
    end
endmodule // fdr_drive_model

// File: testbench/fdr_rate_ctrl_bench.sv
// Purpose: Self-checking bench for the drive rate control registers
// Assumes: Host strobes driven on rising edges
// Notes: Waits cover the two-edge pin latency
`timescale 1ns/1ps
module fdr_rate_ctrl_bench;
    logic clk_sys_in, reset_in, io_wr_in, io_rd_in, enhanced_mode_in;
    logic [9:0] io_addr_in;
    logic [7:0] io_wdata_in, drive_type_config_reg_in, code_a_start_track_in, current_track_in;
    fdr_pkg::fdr_decode_t decode_mode_in;
    fdr_pkg::fdr_rate_type_t drive_rate_type_in;
    logic [7:0] rdat, rv;
    logic p0n, p1n, m0n, m1n, den, lp, crst, pen, xn;
    logic [1:0] rc, dd, sel, spin, r, xd;
    logic [2:0] pc;
    logic [5:0] dly, xl;
    int fails, comparisons;
    logic [7:0] dv [6] = '{8'h1C, 8'h2D, 8'hC4, 8'h1C, 8'h2D, 8'h34};
    logic dm [6] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
    logic [3:0] pe [6] = '{4'hA, 4'h5, 4'hF, 4'h5, 4'hA, 4'h8};
    logic [5:0] lo [8] = '{6'h0, 6'hA, 6'h14, 6'h1F, 6'h29, 6'h34, 6'h3E, 6'h0};
    logic [5:0] hi [8] = '{6'h0, 6'h5, 6'hA, 6'hF, 6'h14, 6'h1A, 6'h1F, 6'h0};
    logic [9:0] lpa [2] = '{10'h3F5, 10'h3F4};

    fdr_rate_ctrl i_fdr_rate_ctrl (
        .clk_sys_in, .reset_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in,
        .io_rdata_out(rdat), .decode_mode_in, .enhanced_mode_in, .drive_type_config_reg_in,
        .drive_rate_type_in, .code_a_start_track_in, .current_track_in,
        .drive_pick_zero_n_out(p0n), .drive_pick_one_n_out(p1n), .motor_out_zero_n_out(m0n),
        .motor_out_one_n_out(m1n), .density_level_out(den), .rate_code_out(rc),
        .drive_density_pins_out(dd), .code_a_out(pc), .code_a_delay_cycles_out(dly),
        .code_a_enable_out(pen), .low_power_out(lp), .controller_reset_out(crst)
    );
    fdr_drive_model i_fdr_drive_model (
        .clk_sys_in, .drive_pick_zero_n_in(p0n), .drive_pick_one_n_in(p1n),
        .motor_out_zero_n_in(m0n), .motor_out_one_n_in(m1n), .selected_out(sel),
        .spinning_out(spin)
    );

    // ----------
    // Bus tasks
    // ----------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        repeat (3) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        io_addr_in <= a;
        io_wdata_in <= d;
        io_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        io_wr_in <= 1'b0;
        tick();
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        io_addr_in <= a;
        io_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        io_rd_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        d = rdat;
    endtask
    task automatic rdc(input logic [9:0] a, input logic [7:0] e);
        rd(a, rv);
        chk(rv, e);
    endtask
    task automatic test_done();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        repeat (8000) @(posedge clk_sys_in);
        fails++;
        test_done();
    end

    // ----------
    // Tests
    // ----------
    initial begin
        {reset_in, io_wr_in, io_rd_in, enhanced_mode_in} = 4'h8;
        {io_addr_in, io_wdata_in, current_track_in} = 26'h0;
        drive_type_config_reg_in = 8'hE4;
        code_a_start_track_in = 8'h05;
        decode_mode_in = fdr_pkg::FDR_DEC_NORMAL;
        drive_rate_type_in = fdr_pkg::FDR_TYPE_STD;
        repeat (12) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        tick();
        chk({1'h0, crst, rc, p1n, p0n, m1n, m0n}, 8'h6F);
        foreach (dv[i]) begin
            @(posedge clk_sys_in);
            decode_mode_in <= fdr_pkg::fdr_decode_t'(dm[i]);
            wr(10'h3F2, dv[i]);
            chk({4'h0, p1n, p0n, m1n, m0n}, {4'h0, pe[i]});
            chk({4'h0, sel, spin}, {4'h0, ~pe[i]});
            rdc(10'h3F2, dv[i]);
        end
        wr(10'h3F3, 8'hFF);
        rdc(10'h3F3, 8'h03);
        wr(10'h3F3, 8'h02);
        wr(10'h3F2, 8'h10);
        chk({6'h0, crst, m0n}, 8'h02);
        rdc(10'h3F3, 8'h02);
        @(posedge clk_sys_in);
        enhanced_mode_in <= 1'b1;
        wr(10'h3F3, 8'h0D);
        for (int s = 0; s < 4; s++) begin
            wr(10'h3F2, 8'h04 | 8'(s));
            rd(10'h3F3, rv);
            chk(rv & 8'h3F, {2'h0, 2'(s), 4'hD});
        end
        @(posedge clk_sys_in);
        enhanced_mode_in <= 1'b0;
        rdc(10'h3F3, 8'h01);
        for (int t = 0; t < 4; t++) begin
            for (int s = 0; s < 4; s++) begin
                @(posedge clk_sys_in);
                drive_rate_type_in <= fdr_pkg::fdr_rate_type_t'(t);
                wr(10'h3F4, 8'(s));
                r = 2'(s);
                xn = (r == 2'h0 || r == 2'h3);
                case (t)
                    0: xd = {r[0], xn};
                    1: xd = {r[0], !xn};
                    2: xd = {r[0], r[1]};
                    default: xd = {r[1], r[0]};
                endcase
                xl = (t == 2 && r == 2'h1) ? 6'h05 : (r == 2'h3) ? 6'h0A : 6'h1F;
                chk({3'h0, dd, den, rc}, {3'h0, xd, xn, r});
                chk({2'h0, dly}, {2'h0, xl});
            end
        end
        for (int c = 1; c < 8; c++) begin
            @(posedge clk_sys_in);
            drive_rate_type_in <= fdr_pkg::FDR_TYPE_STD;
            wr(10'h3F4, {3'h0, 3'(c), 2'h2});
            chk({5'h0, pc}, 8'(c));
            chk({2'h0, dly}, {2'h0, lo[c]});
            @(posedge clk_sys_in);
            drive_rate_type_in <= fdr_pkg::FDR_TYPE_TAPE;
            wr(10'h3F4, {3'h0, 3'(c), 2'h1});
            chk({2'h0, dly}, {2'h0, hi[c]});
        end
        @(posedge clk_sys_in);
        drive_rate_type_in <= fdr_pkg::FDR_TYPE_STD;
        wr(10'h3F7, 8'h00);
        chk({6'h0, rc}, 8'h00);
        wr(10'h3F4, 8'h03);
        chk({6'h0, rc}, 8'h03);
        @(posedge clk_sys_in);
        current_track_in <= 8'h04;
        tick();
        chk({7'h0, pen}, 8'h00);
        @(posedge clk_sys_in);
        current_track_in <= 8'h05;
        tick();
        chk({7'h0, pen}, 8'h01);
        foreach (lpa[k]) begin
            wr(10'h3F4, 8'h42);
            chk({7'h0, lp}, 8'h01);
            rd(lpa[k], rv);
            chk({7'h0, lp}, 8'h00);
        end
        wr(10'h3F4, 8'h42);
        wr(10'h3F4, 8'h81);
        chk({6'h0, crst, lp}, 8'h02);
        repeat (10) tick();
        chk({5'h0, crst, rc}, 8'h01);
        rdc(10'h3F3, 8'h01);
        rdc(10'h3F2, 8'h07);
        rdc(10'h3F6, 8'h00);
        @(posedge clk_sys_in);
        reset_in <= 1'b1;
        tick();
        @(posedge clk_sys_in);
        reset_in <= 1'b0;
        tick();
        chk({5'h0, crst, rc}, 8'h06);
        rdc(10'h3F3, 8'h00);
        test_done();
    end
endmodule // fdr_rate_ctrl_bench
